// *** hw/sar_pkg.sv ***
// Shared constants, command codes and helpers for the sensor result readout link.
// Assumes both link ends are clocked by clk at 100 MHz and import this package whole.
package sar_pkg;

  localparam int RESULT_W = 24;

  // Command bytes; the low bits of write and select carry their argument
  localparam logic [7:0] CMD_READ      = 8'h12;
  localparam logic [7:0] CMD_READ_CONT = 8'h14;
  localparam logic [7:0] CMD_STOP_CONT = 8'h16;
  localparam logic [7:0] CMD_WRITE_REG = 8'h40;
  localparam logic [7:0] CMD_SEL_CHAN  = 8'h50;

  localparam logic [5:0] CMD_LAST_BIT   = 6'h07;
  localparam logic [5:0] WRITE_LAST_BIT = 6'h0F;
  // Twelve data bits in: eight of the top byte plus half of the next
  localparam logic [4:0] RELEASE_BIT    = 5'h0C;

  localparam logic [1:0] REG_GAIN     = 2'h0;
  localparam logic [1:0] REG_OSR      = 2'h1;
  localparam logic [1:0] REG_CTRL_ONE = 2'h2;
  localparam logic [1:0] REG_CTRL_TWO = 2'h3;

  localparam logic [7:0] GAIN_RST     = 8'h01;
  localparam logic [7:0] OSR_RST      = 8'h06;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;

  localparam logic CHAN_TEMP  = 1'b0;
  localparam logic CHAN_PRESS = 1'b1;

  // Ratio is held as its base-two logarithm: 8 means 256
  localparam logic [7:0] PRESS_GAIN     = 8'h80;
  localparam logic [7:0] PRESS_OSR      = 8'h08;
  localparam logic [7:0] PRESS_CTRL_ONE = 8'hE1;
  localparam logic [7:0] PRESS_CTRL_TWO = 8'h03;

  localparam logic [1:0] SETTLE_LOWS = 2'h3;

  localparam logic [5:0] READ_FRAME_BITS  = 6'h20;
  localparam logic [5:0] CONT_FRAME_BITS  = 6'h18;
  localparam logic [5:0] WRITE_FRAME_BITS = 6'h10;
  localparam logic [5:0] CMD_FRAME_BITS   = 6'h08;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {OP_READ, OP_READ_CONT, OP_STOP_CONT, OP_SEL_CHAN} sar_op_type;

  // Stable level of a three-stage synchroniser: moves only when stages two and three agree
  function automatic logic sar_settle(input logic held, input logic s2, input logic s3);
    return (s2 == s3) ? s3 : held;
  endfunction

  // Pressure set-up frames, sent from step 5 down to step 2
  function automatic logic [15:0] sar_press_cfg(input logic [2:0] step);
    case (step)
      3'h5:    return {CMD_WRITE_REG | {6'h00, REG_GAIN}, PRESS_GAIN};
      3'h4:    return {CMD_WRITE_REG | {6'h00, REG_OSR}, PRESS_OSR};
      3'h3:    return {CMD_WRITE_REG | {6'h00, REG_CTRL_ONE}, PRESS_CTRL_ONE};
      3'h2:    return {CMD_WRITE_REG | {6'h00, REG_CTRL_TWO}, PRESS_CTRL_TWO};
      default: return 16'h0000;
    endcase
  endfunction

endpackage

// *** hw/sar_link_if.sv ***
// Serial link between the readout device and its master.
// Assumes a pull-up on the data-out line; the wire level is resolved here.
`timescale 1ns/100ps
`default_nettype none
interface sar_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic misoEnN;
  logic misoLine;
  logic resultReadyN;

  assign misoLine = misoEnN ? 1'b1 : miso;

  modport device (input sclk, input csN, input mosi, output miso, output misoEnN,
                  output resultReadyN);
  modport host (output sclk, output csN, output mosi, input misoLine, input resultReadyN);
endinterface
`default_nettype wire

// *** hw/sar_readout_device.sv ***
// Readout device end: result FIFO, result register, ready line and serial slave.
// Assumes link pins are asynchronous to clk and the converter pushes results on clk.
`timescale 1ns/100ps
`default_nettype none
module sar_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (clkEn && push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr <= bump(wrPtr);
      end
      if (pop) begin
        rdPtr <= bump(rdPtr);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sar_readout_device
  import sar_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  sar_link_if.device               link,
  input  wire logic                convValid,
  input  wire logic [RESULT_W-1:0] convData,
  output logic                     convReady,
  output logic                     chanSel,
  output logic [7:0]               amplifierGain,
  output logic [7:0]               oversamplingRatio,
  output logic [7:0]               controlRegOne,
  output logic [7:0]               controlRegTwo,
  output logic                     contActive
);
  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_SEND, PH_SKIP} sar_phase_type;

  sar_phase_type       phase;
  logic [2:0]          sclkSync;
  logic [2:0]          csSync;
  logic [2:0]          mosiSync;
  logic                sclkLvl;
  logic                csNLvl;
  logic                mosiLvl;
  logic                sclkNow;
  logic                csNNow;
  logic                sclkRise;
  logic                sclkFall;
  logic                frameStart;
  logic                frameEnd;
  logic [7:0]          rxShift;
  logic [7:0]          next_rx;
  logic [5:0]          bitCnt;
  logic [4:0]          dataCnt;
  logic [1:0]          regIdx;
  logic [RESULT_W-1:0] resultReg;
  logic [RESULT_W-1:0] txShift;
  logic                fifoValid;
  logic [RESULT_W-1:0] fifoData;
  logic                drainReady;

  assign sclkNow    = sar_settle(sclkLvl, sclkSync[1], sclkSync[2]);
  assign csNNow     = sar_settle(csNLvl, csSync[1], csSync[2]);
  assign sclkRise   = sclkNow && !sclkLvl && !csNLvl;
  assign sclkFall   = !sclkNow && sclkLvl && !csNLvl;
  assign frameStart = csNLvl && !csNNow;
  assign frameEnd   = !csNLvl && csNNow;
  assign next_rx    = {rxShift[6:0], mosiLvl};
  // Results queue while a frame is open so the word being shifted never changes
  assign drainReady = csNLvl && csNNow;

  sar_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (convValid),
    .inReady  (convReady),
    .inData   (convData),
    .outValid (fifoValid),
    .outReady (drainReady),
    .outData  (fifoData)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSync <= 3'h0;
      csSync   <= 3'h7;
      mosiSync <= 3'h0;
      sclkLvl  <= 1'b0;
      csNLvl   <= 1'b1;
      mosiLvl  <= 1'b0;
    end else if (clkEn) begin
      sclkSync <= {sclkSync[1:0], link.sclk};
      csSync   <= {csSync[1:0], link.csN};
      mosiSync <= {mosiSync[1:0], link.mosi};
      sclkLvl  <= sclkNow;
      csNLvl   <= csNNow;
      mosiLvl  <= sar_settle(mosiLvl, mosiSync[1], mosiSync[2]);
    end
  end

  // Result register and ready line; loads and releases never share a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resultReg         <= '0;
      link.resultReadyN <= 1'b1;
    end else if (clkEn) begin
      if (fifoValid && drainReady) begin
        resultReg         <= fifoData;
        link.resultReadyN <= 1'b0;
      end else if (phase == PH_SEND && sclkRise && dataCnt == RELEASE_BIT - 5'h01) begin
        link.resultReadyN <= 1'b1;
      end
      // With no read the line simply holds low
    end
  end

  // Serial slave: bits in on rising edges, bits out on falling edges, a continuous frame's first bit at chip-select fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase             <= PH_CMD;
      rxShift           <= 8'h00;
      bitCnt            <= 6'h00;
      dataCnt           <= 5'h00;
      regIdx            <= REG_GAIN;
      txShift           <= '0;
      contActive        <= 1'b0;
      chanSel           <= CHAN_TEMP;
      amplifierGain     <= GAIN_RST;
      oversamplingRatio <= OSR_RST;
      controlRegOne     <= CTRL_ONE_RST;
      controlRegTwo     <= CTRL_TWO_RST;
      link.miso         <= 1'b0;
      link.misoEnN      <= 1'b1;
    end else if (clkEn) begin
      if (frameStart) begin
        bitCnt  <= 6'h00;
        dataCnt <= 5'h00;
        rxShift <= 8'h00;
        // In continuous mode a pending result leaves without a command
        if (contActive && !link.resultReadyN) begin
          phase        <= PH_SEND;
          link.miso    <= resultReg[RESULT_W-1];
          txShift      <= resultReg << 1;
          link.misoEnN <= 1'b0;
        end else begin
          phase <= PH_CMD;
        end
      end else if (frameEnd) begin
        phase        <= PH_CMD;
        link.misoEnN <= 1'b1;
      end else if (sclkRise) begin
        rxShift <= next_rx;
        bitCnt  <= bitCnt + 6'h01;
        if (phase == PH_SEND) begin
          dataCnt <= dataCnt + 5'h01;
        end
        if (bitCnt == CMD_LAST_BIT) begin
          if (next_rx == CMD_STOP_CONT) begin
            contActive <= 1'b0;
          end
          if (phase == PH_CMD) begin
            if (next_rx == CMD_READ || next_rx == CMD_READ_CONT) begin
              phase        <= PH_SEND;
              txShift      <= resultReg;
              link.misoEnN <= 1'b0;
              if (next_rx == CMD_READ_CONT) begin
                contActive <= 1'b1;
              end
            end else if (next_rx[7:2] == CMD_WRITE_REG[7:2]) begin
              phase  <= PH_DATA;
              regIdx <= next_rx[1:0];
            end else if (next_rx[7:1] == CMD_SEL_CHAN[7:1]) begin
              chanSel <= next_rx[0];
              phase   <= PH_SKIP;
            end else begin
              phase <= PH_SKIP;
            end
          end
        end else if (phase == PH_DATA && bitCnt == WRITE_LAST_BIT) begin
          phase <= PH_SKIP;
          case (regIdx)
            REG_GAIN:     amplifierGain     <= next_rx;
            REG_OSR:      oversamplingRatio <= next_rx;
            REG_CTRL_ONE: controlRegOne     <= next_rx;
            default:      controlRegTwo     <= next_rx;
          endcase
        end
      end else if (sclkFall && phase == PH_SEND) begin
        link.miso <= txShift[RESULT_W-1];
        txShift   <= txShift << 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/sar_readout_host.sv ***
// Master end: makes the serial clock, sets up channels and fetches results.
// Assumes the device's data-out and ready lines are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module sar_readout_host
  import sar_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           clkEn,
  sar_link_if.host            link,
  input  wire logic           opValid,
  input  wire sar_op_type     opCode,
  input  wire logic           opChan,
  output logic                opReady,
  output logic                resValid,
  output logic [RESULT_W-1:0] resData,
  output logic                resChan,
  output logic                hostCont,
  output logic                settling
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} sar_host_state_type;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  sar_host_state_type  state;
  logic [7:0]          divCnt;
  logic                divEnd;
  logic [31:0]         txBits;
  logic [5:0]          frameLen;
  logic [5:0]          bitCnt;
  logic [RESULT_W-1:0] rxShift;
  logic                frameRead;
  logic                frameSel;
  logic [2:0]          seqLeft;
  logic                seqChan;
  logic                curChan;
  logic [2:0]          misoSync;
  logic [2:0]          rdySync;
  logic                misoLvl;
  logic                rdyLvl;
  logic                rdyNow;
  logic                rdyFall;
  logic                selDone;
  logic [1:0]          settleCnt;

  assign divEnd  = (divCnt == HALF_LAST);
  assign rdyNow  = sar_settle(rdyLvl, rdySync[1], rdySync[2]);
  assign rdyFall = rdyLvl && !rdyNow;
  assign selDone = (state == H_GAP) && divEnd && frameSel;
  // A read waits for a fresh result and for the channel to settle
  assign opReady = (state == H_IDLE) && (seqLeft == 3'h0) &&
                   ((opCode != OP_READ && opCode != OP_READ_CONT) || (!settling && !rdyLvl));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misoSync <= 3'h7;
      rdySync  <= 3'h7;
      misoLvl  <= 1'b1;
      rdyLvl   <= 1'b1;
    end else if (clkEn) begin
      misoSync <= {misoSync[1:0], link.misoLine};
      rdySync  <= {rdySync[1:0], link.resultReadyN};
      misoLvl  <= sar_settle(misoLvl, misoSync[1], misoSync[2]);
      rdyLvl   <= rdyNow;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settling  <= 1'b0;
      settleCnt <= 2'h0;
    end else if (clkEn) begin
      if (selDone) begin
        settling  <= 1'b1;
        settleCnt <= 2'h0;
      end else if (settling && rdyFall) begin
        if (settleCnt == SETTLE_LOWS - 2'h1) begin
          settling <= 1'b0;
        end else begin
          settleCnt <= settleCnt + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= H_IDLE;
      divCnt    <= 8'h00;
      txBits    <= 32'h0;
      frameLen  <= 6'h00;
      bitCnt    <= 6'h00;
      rxShift   <= '0;
      frameRead <= 1'b0;
      frameSel  <= 1'b0;
      seqLeft   <= 3'h0;
      seqChan   <= CHAN_TEMP;
      curChan   <= CHAN_TEMP;
      hostCont  <= 1'b0;
      resValid  <= 1'b0;
      resData   <= '0;
      resChan   <= CHAN_TEMP;
      link.sclk <= 1'b0;
      link.csN  <= 1'b1;
      link.mosi <= 1'b0;
    end else if (clkEn) begin
      resValid <= 1'b0;
      case (state)
        H_IDLE: begin
          divCnt <= 8'h00;
          bitCnt <= 6'h00;
          if (seqLeft != 3'h0) begin
            seqLeft  <= seqLeft - 3'h1;
            state    <= H_LOW;
            link.csN <= 1'b0;
            if (seqLeft == 3'h1) begin
              txBits   <= {CMD_SEL_CHAN | {7'h00, seqChan}, 24'h0};
              frameLen <= CMD_FRAME_BITS;
              frameSel <= 1'b1;
            end else begin
              txBits   <= {sar_press_cfg(seqLeft), 16'h0};
              frameLen <= WRITE_FRAME_BITS;
            end
          end else if (opValid && opReady) begin
            case (opCode)
              OP_READ: begin
                txBits    <= hostCont ? 32'h0 : {CMD_READ, 24'h0};
                frameLen  <= hostCont ? CONT_FRAME_BITS : READ_FRAME_BITS;
                frameRead <= 1'b1;
                state     <= H_LOW;
                link.csN  <= 1'b0;
              end
              OP_READ_CONT: begin
                // The entering command is itself a read: the word follows in the same frame
                txBits    <= {CMD_READ_CONT, 24'h0};
                frameLen  <= READ_FRAME_BITS;
                frameRead <= 1'b1;
                hostCont  <= 1'b1;
                state     <= H_LOW;
                link.csN  <= 1'b0;
              end
              OP_STOP_CONT: begin
                txBits   <= {CMD_STOP_CONT, 24'h0};
                frameLen <= CMD_FRAME_BITS;
                hostCont <= 1'b0;
                state    <= H_LOW;
                link.csN <= 1'b0;
              end
              default: begin
                // Pressure needs its gain and filter set before selecting
                seqChan <= opChan;
                seqLeft <= (opChan == CHAN_PRESS) ? 3'h5 : 3'h1;
              end
            endcase
          end
        end
        H_LOW: begin
          divCnt <= divCnt + 8'h01;
          if (divCnt == 8'h00) begin
            link.mosi <= txBits[31];
          end
          if (divEnd) begin
            link.sclk <= 1'b1;
            divCnt    <= 8'h00;
            state     <= H_HIGH;
          end
        end
        H_HIGH: begin
          divCnt <= divCnt + 8'h01;
          // Sampling at the end of the high phase leaves a whole period for sync delay
          if (divEnd) begin
            link.sclk <= 1'b0;
            rxShift   <= {rxShift[RESULT_W-2:0], misoLvl};
            txBits    <= txBits << 1;
            bitCnt    <= bitCnt + 6'h01;
            divCnt    <= 8'h00;
            state     <= (bitCnt == frameLen - 6'h01) ? H_TAIL : H_LOW;
          end
        end
        H_TAIL: begin
          divCnt <= divCnt + 8'h01;
          if (divEnd) begin
            link.csN <= 1'b1;
            divCnt   <= 8'h00;
            state    <= H_GAP;
          end
        end
        default: begin
          divCnt <= divCnt + 8'h01;
          if (divEnd) begin
            state <= H_IDLE;
            if (frameRead) begin
              resValid  <= 1'b1;
              resData   <= rxShift;
              resChan   <= curChan;
              frameRead <= 1'b0;
            end
            if (frameSel) begin
              curChan  <= seqChan;
              frameSel <= 1'b0;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** dv/sar_link_chk.sv ***
// Checker for the serial link between the device end and the host end.
// Assumes every link signal is registered on the shared clk; sits beside the link.
`timescale 1ns/100ps
`default_nettype none
module sar_link_chk #(
  parameter int HALF_CYC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic miso,
  input wire logic misoEnN,
  input wire logic resultReadyN
);
  logic [5:0] edgeCnt;
  logic [4:0] hiCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Serial clock rising edges seen so far in the open frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt <= 6'h00;
    end else if (csN) begin
      edgeCnt <= 6'h00;
    end else if ($rose(sclk)) begin
      edgeCnt <= edgeCnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiCnt <= 5'h00;
    end else begin
      hiCnt <= sclk ? hiCnt + 5'h01 : 5'h00;
    end
  end

  AST_SCLK_IDLE: assert property (csN |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_CS_GAP: assert property ($rose(csN) |-> csN [*8])
    else $error("frame gap too short");
  AST_SCLK_HALF: assert property ($fell(sclk) |-> int'(hiCnt) == HALF_CYC)
    else $error("serial clock high phase wrong length");
  // Read frame: 8 command bits then 12 data bits; continuous frame: 12 data bits
  AST_READY_MID: assert property ($rose(resultReadyN) |-> edgeCnt == 6'h14 || edgeCnt == 6'h0C)
    else $error("ready line released at wrong bit");
  AST_READY_RISE: assert property ($rose(resultReadyN) |-> !csN && !misoEnN)
    else $error("ready line released without a read");
  AST_READY_FALL: assert property ($fell(resultReadyN) |-> edgeCnt == 6'h00)
    else $error("ready line fell in mid frame");
  AST_MISO_HOLD: assert property (sclk && !misoEnN |-> $stable(miso))
    else $error("data out changed while clock high");
  AST_MISO_IN_FRAME: assert property ($fell(misoEnN) |-> !csN)
    else $error("data out driven outside a frame");
  AST_MISO_RELEASE: assert property ($rose(csN) |-> ##[1:8] misoEnN)
    else $error("data out not released after frame");
endmodule
`default_nettype wire

// *** dv/sensor_adc_spi_readout_test.sv ***
// Bench joining the device end and the host end over one link.
// Assumes the package and both ends are compiled first; clk is 100 MHz.
`timescale 1ns/100ps
`default_nettype none
module sensor_adc_spi_readout_test
  import sar_pkg::*;
;
  typedef struct packed {logic [23:0] word; logic [23:0] expData;} sar_row_type;

  logic                clk;
  logic                rst_n;
  logic                clkEn;
  logic                convValid;
  logic [RESULT_W-1:0] convData;
  logic                convReady;
  logic                chanSel;
  logic [7:0]          amplifierGain;
  logic [7:0]          oversamplingRatio;
  logic [7:0]          controlRegOne;
  logic [7:0]          controlRegTwo;
  logic                contActive;
  logic                opValid;
  sar_op_type          opCode;
  logic                opChan;
  logic                opReady;
  logic                resValid;
  logic [RESULT_W-1:0] resData;
  logic                resChan;
  logic                hostCont;
  logic                settling;
  int                  fail_count;
  int                  checks;
  sar_row_type         rows [4] = '{'{24'h000001, 24'h000001}, '{24'hFFFFFF, 24'hFFFFFF},
                                    '{24'h800000, 24'h800000}, '{24'h5A3C96, 24'h5A3C96}};

  sar_link_if linkBus ();

  sar_readout_device sar_readout_device_inst (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .link(linkBus.device),
    .convValid(convValid), .convData(convData), .convReady(convReady), .chanSel(chanSel),
    .amplifierGain(amplifierGain), .oversamplingRatio(oversamplingRatio),
    .controlRegOne(controlRegOne), .controlRegTwo(controlRegTwo), .contActive(contActive));

  sar_readout_host sar_readout_host_inst (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .link(linkBus.host),
    .opValid(opValid), .opCode(opCode), .opChan(opChan), .opReady(opReady),
    .resValid(resValid), .resData(resData), .resChan(resChan), .hostCont(hostCont),
    .settling(settling));

  sar_link_chk #(.HALF_CYC(SCLK_HALF_CYC)) sar_link_chk_inst (
    .clk(clk), .rst_n(rst_n), .sclk(linkBus.sclk), .csN(linkBus.csN), .miso(linkBus.miso),
    .misoEnN(linkBus.misoEnN), .resultReadyN(linkBus.resultReadyN));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic push(input logic [23:0] w);
    @(negedge clk);
    convValid = 1'b1;
    convData = w;
    @(negedge clk);
    convValid = 1'b0;
  endtask

  // Waits for opReady a little after the falling edge, so the taking edge is known
  task automatic doOp(input sar_op_type c, input logic ch);
    int n;
    n = 0;
    @(negedge clk);
    opValid = 1'b1;
    opCode = c;
    opChan = ch;
    #1;
    while (opReady !== 1'b1 && n < 4000) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    opValid = 1'b0;
    chk(n < 4000, 1'b1);
  endtask

  task automatic waitIdle(input logic isRes);
    int n;
    n = 0;
    while ((isRes ? resValid : opReady) !== 1'b1 && n < 4000) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk(n < 4000, 1'b1);
  endtask

  task automatic readChk(input sar_op_type c, input logic [23:0] exp);
    doOp(c, 1'b0);
    waitIdle(1'b1);
    chk(resData, exp);
    chk(linkBus.resultReadyN, 1'b1);
  endtask

  task automatic conclude();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole sequence needs about 7k cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    convValid = 1'b0;
    convData = '0;
    opValid = 1'b0;
    opCode = OP_READ;
    opChan = 1'b0;
    fail_count = 0;
    checks = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      push(rows[i].word);
      @(negedge clk);
      chk(linkBus.resultReadyN, 1'b0);
      readChk(OP_READ, rows[i].expData);
      chk(resChan, CHAN_TEMP);
    end
    // Unread result stays pending, then a newer one replaces it
    push(24'h5A5A5A);
    repeat (300) @(negedge clk);
    chk(linkBus.resultReadyN, 1'b0);
    push(24'hC3C3C3);
    readChk(OP_READ, 24'hC3C3C3);
    // Queue fills while a frame is open and drains once it closes
    push(24'h111111);
    doOp(OP_READ, 1'b0);
    repeat (12) @(negedge clk);
    for (int i = 2; i < 6; i++) push({6{i[3:0]}});
    chk(convReady, 1'b0);
    waitIdle(1'b1);
    chk(resData, 24'h111111);
    readChk(OP_READ, 24'h555555);
    chk(convReady, 1'b1);
    push(24'h0ABCDE);
    readChk(OP_READ_CONT, 24'h0ABCDE);
    chk(contActive, 1'b1);
    chk(hostCont, 1'b1);
    push(24'hF0E1D2);
    readChk(OP_READ, 24'hF0E1D2);
    doOp(OP_STOP_CONT, 1'b0);
    waitIdle(1'b0);
    chk(contActive, 1'b0);
    chk(hostCont, 1'b0);
    doOp(OP_SEL_CHAN, CHAN_PRESS);
    waitIdle(1'b0);
    chk(chanSel, CHAN_PRESS);
    chk(amplifierGain, 8'h80);
    chk(oversamplingRatio, PRESS_OSR);
    chk(controlRegOne, 8'hE1);
    chk(controlRegTwo, 8'h03);
    chk(settling, 1'b1);
    push(24'h777777);
    @(negedge clk);
    opCode = OP_READ;
    opValid = 1'b1;
    repeat (20) @(negedge clk);
    chk(opReady, 1'b0);
    chk(linkBus.csN, 1'b1);
    opValid = 1'b0;
    rst_n = 1'b0;
    @(negedge clk);
    chk(chanSel, CHAN_TEMP);
    chk(amplifierGain, GAIN_RST);
    chk(oversamplingRatio, OSR_RST);
    chk(controlRegOne, CTRL_ONE_RST);
    chk(controlRegTwo, CTRL_TWO_RST);
    chk(settling, 1'b0);
    chk(linkBus.resultReadyN, 1'b1);
    chk(convReady, 1'b1);
    rst_n = 1'b1;
    // A frozen block must not take a converter word
    clkEn = 1'b0;
    push(24'h13579B);
    repeat (4) @(negedge clk);
    chk(linkBus.resultReadyN, 1'b1);
    clkEn = 1'b1;
    push(24'h2468AC);
    readChk(OP_READ, 24'h2468AC);
    conclude();
  end
endmodule
`default_nettype wire
